//--- src/ptgs_top.sv
// Trigger selection, gating and pulse/reference timing of the pulse instrument
//
// Summary of operation
// RL1: every accepted trigger yields main and reference pulses
// RL2: main pulse width programmable from 2 to 20 us
// RL3: reference pulse width never depends on settings
// RL4: positive delay: reference first, main after delay
// RL5: negative delay: main first, reference after delay
// RL6: four trigger modes; only selected source triggers
// RL7: internal mode repeats at programmed trigger rate
// RL8: external mode triggers only from edge input
// RL9: manual mode triggers only on button press
// RL10: hold mode never triggers
// RL11: gate at chosen level suppresses triggering
// RL12: gating never truncates a running main pulse
// RL13: delay and rate set remotely; rate internal-only
// RL14: external trigger on rising edge of input
// RL15: reference pulse lasts about 100 ns
// RL16: undriven gate input lets triggering proceed
// RL17: triggers during a running sequence are dropped
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ptgs_cfg.svh"
module ptgs_top import ptgs_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic external_edge_input,
  input wire logic gate_input,
  input wire logic single_shot_button,
  output logic pulse_out,
  output logic sync_out,
  output logic gate_pull_up,
  input wire logic [`PTGS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PTGS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ptgs_state_t s;
  ptgs_state_t next_s;
  ptgs_wr_t wr;
  logic wr_en;
  logic [`PTGS_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic [`PTGS_NPIN-1:0] pins;
  logic ext_rise;
  logic btn_rise;
  logic gate_supp;
  logic rate_tick;
  logic sel_external_edge_input;
  logic accept;
  logic [8:0] w_eff;
  logic [15:0] d_mag;
  logic d_neg;

  // Pins are asynchronous; filtering adds four cycles of trigger latency
  ptgs_insync u_insync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .raw({single_shot_button, gate_input, external_edge_input}),
    .clean(pins)
  );

  ptgs_axil u_axil (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr(wr),
    .wr_en(wr_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Byte strobes applied lane by lane
  function automatic logic [31:0] ptgs_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign ext_rise = pins[`PTGS_PIN_EXT] && !s.prev[`PTGS_PIN_EXT]; // see RL14
  assign btn_rise = pins[`PTGS_PIN_BTN] && !s.prev[`PTGS_PIN_BTN];
  // Idle gate sits at the non-suppressing level through the selected pull
  assign gate_supp = s.gate_hi ? pins[`PTGS_PIN_GATE] : !pins[`PTGS_PIN_GATE]; // see RL11
  assign gate_pull_up = !s.gate_hi; // see RL16
  assign rate_tick = (s.mode == PTGS_INTERNAL) && ({1'b0, s.rate_cnt} + 25'h1 >= {1'b0, s.period}); // see RL7

  // Only the selected source reaches acceptance
  always_comb begin
    unique case (s.mode)
      PTGS_INTERNAL: sel_external_edge_input = rate_tick; // see RL6
      PTGS_EXTERNAL: sel_external_edge_input = ext_rise; // see RL8
      PTGS_MANUAL: sel_external_edge_input = btn_rise; // see RL9
      PTGS_HOLD: sel_external_edge_input = 1'b0; // see RL10
    endcase
  end

  // Gate only blocks the start of a sequence, so a running pulse always completes
  assign accept = (s.seq == PTGS_IDLE) && sel_external_edge_input && !gate_supp; // see RL12 RL17

  // Out-of-range widths clamp instead of being refused, so a bad write still gives a legal pulse
  always_comb begin
    w_eff = s.width[8:0];
    if (s.width < 16'(`PTGS_WIDTH_MIN_CYC)) begin
      w_eff = 9'(`PTGS_WIDTH_MIN_CYC); // see RL2
    end else if (s.width > 16'(`PTGS_WIDTH_MAX_CYC)) begin
      w_eff = 9'(`PTGS_WIDTH_MAX_CYC); // see RL2
    end
  end

  // Delay is two's complement; magnitude taken once here
  assign d_neg = s.delay[15];
  assign d_mag = d_neg ? 16'(-s.delay) : s.delay;

  always_comb begin
    next_s = s;
    next_s.prev = pins;
    // Parked at zero so the rate restarts cleanly on entering internal mode
    if (s.mode == PTGS_INTERNAL) begin
      next_s.rate_cnt = rate_tick ? 24'h0 : s.rate_cnt + 24'h1;
    end else begin
      next_s.rate_cnt = 24'h0; // see RL13
    end
    if (wr_en) begin
      unique case (wr.addr)
        `PTGS_OFF_CTRL: begin
          next_s.mode = ptgs_mode_t'(2'(ptgs_merge({29'h0, s.gate_hi, s.mode}, wr.data, wr.strb))); // see RL6
          next_s.gate_hi = wr.strb[0] ? wr.data[`PTGS_CTRL_GATE_BIT] : s.gate_hi; // see RL11
        end
        `PTGS_OFF_WIDTH: next_s.width = 16'(ptgs_merge({16'h0, s.width}, wr.data, wr.strb)); // see RL2
        `PTGS_OFF_DELAY: next_s.delay = 16'(ptgs_merge({16'h0, s.delay}, wr.data, wr.strb)); // see RL13
        `PTGS_OFF_PERIOD: next_s.period = 24'(ptgs_merge({8'h0, s.period}, wr.data, wr.strb)); // see RL13
        default: begin
        end
      endcase
    end
    unique case (s.seq)
      PTGS_IDLE: begin
        next_s.pulse_out = 1'b0;
        next_s.sync_out = 1'b0;
        if (accept) begin
          // Timing latched here; later register writes cannot disturb this sequence
          next_s.seq = PTGS_RUN; // see RL1
          next_s.t = '0;
          next_s.ms = d_neg ? '0 : `PTGS_T_W'(d_mag); // see RL4
          next_s.ss = d_neg ? `PTGS_T_W'(d_mag) : '0; // see RL5
          next_s.me = (d_neg ? '0 : `PTGS_T_W'(d_mag)) + `PTGS_T_W'(w_eff);
          next_s.se = (d_neg ? `PTGS_T_W'(d_mag) : '0) + `PTGS_T_W'(`PTGS_SYNC_CYC); // see RL3 RL15
          if (d_neg) begin
            next_s.fin = `PTGS_T_W'(d_mag) + `PTGS_T_W'(`PTGS_SYNC_CYC);
            if (`PTGS_T_W'(w_eff) > next_s.fin) begin
              next_s.fin = `PTGS_T_W'(w_eff);
            end
          end else begin
            next_s.fin = `PTGS_T_W'(d_mag) + `PTGS_T_W'(w_eff);
          end
        end
      end
      PTGS_RUN: begin
        next_s.pulse_out = (s.t >= s.ms) && (s.t < s.me); // see RL1 RL2
        next_s.sync_out = (s.t >= s.ss) && (s.t < s.se); // see RL1 RL3
        next_s.t = s.t + `PTGS_T_W'(1);
        if (s.t == s.fin) begin
          next_s.seq = PTGS_IDLE;
        end
      end
    endcase
  end

  // Hold mode after reset keeps the outputs quiet until software arms a source
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.mode <= PTGS_HOLD;
      s.gate_hi <= `PTGS_RST_GATE_HI;
      s.width <= `PTGS_RST_WIDTH;
      s.delay <= `PTGS_RST_DELAY;
      s.period <= `PTGS_RST_PERIOD;
      s.seq <= PTGS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Reads see live state; status bits may move between two reads
  always_comb begin
    unique case (rd_addr)
      `PTGS_OFF_CTRL: rd_data = {29'h0, s.gate_hi, s.mode};
      `PTGS_OFF_WIDTH: rd_data = {16'h0, s.width};
      `PTGS_OFF_DELAY: rd_data = {16'h0, s.delay};
      `PTGS_OFF_PERIOD: rd_data = {8'h0, s.period};
      `PTGS_OFF_STATUS: rd_data = {26'h0, s.mode, gate_supp, s.sync_out, s.pulse_out, s.seq == PTGS_RUN};
      default: rd_data = 32'h0;
    endcase
  end

  assign pulse_out = s.pulse_out;
  assign sync_out = s.sync_out;

  // Checking aids: seen flags per sequence and length of the current main pulse
  logic seen_main;
  logic seen_sync;
  logic [8:0] hi_len;
  logic [8:0] w_lat;
  logic run_neg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen_main <= 1'b0;
      seen_sync <= 1'b0;
      hi_len <= 9'h0;
      w_lat <= 9'h0;
      run_neg <= 1'b0;
    end else begin
      if (accept) begin
        seen_main <= 1'b0;
        seen_sync <= 1'b0;
        w_lat <= w_eff;
        run_neg <= d_neg;
      end else begin
        seen_main <= seen_main | s.pulse_out;
        seen_sync <= seen_sync | s.sync_out;
      end
      hi_len <= s.pulse_out ? hi_len + 9'h1 : 9'h0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_sync_width: assert property ($rose(sync_out) |-> sync_out [*2] ##1 !sync_out) // see RL3 RL15
    else $error("reference pulse width wrong");
  a_both_pulses: assert property ($fell(s.seq == PTGS_RUN) |-> seen_main && seen_sync) // see RL1
    else $error("sequence ended without both pulses");
  a_main_width: assert property ($fell(pulse_out) |-> $past(hi_len) + 9'h1 == w_lat) // see RL2 RL12
    else $error("main pulse width wrong");
  a_width_range: assert property ($fell(pulse_out) |-> w_lat >= 9'h28 && w_lat <= 9'h190) // see RL2
    else $error("main pulse width out of range");
  a_pos_order: assert property ($rose(pulse_out) && !run_neg && !$past(accept, 2) |-> seen_sync) // see RL4
    else $error("main pulse led with positive delay");
  a_neg_order: assert property ($rose(sync_out) && run_neg && !$past(accept, 2) |-> seen_main) // see RL5
    else $error("reference led with negative delay");
  a_hold_quiet: assert property (s.mode == PTGS_HOLD |-> !accept) // see RL10
    else $error("trigger taken in hold mode");
  a_gate_block: assert property (gate_supp |-> !accept) // see RL11
    else $error("trigger taken while gated");
  a_ext_source: assert property (accept && s.mode == PTGS_EXTERNAL |-> pins[`PTGS_PIN_EXT] && !s.prev[`PTGS_PIN_EXT]) // see RL14
    else $error("external trigger without rising edge");
  a_btn_source: assert property (accept && s.mode == PTGS_MANUAL |-> $rose(pins[`PTGS_PIN_BTN])) // see RL9
    else $error("manual trigger without button press");
  a_int_rate: assert property (s.mode == PTGS_INTERNAL && rate_tick ##1 s.mode == PTGS_INTERNAL |-> s.rate_cnt == 24'h0) // see RL7
    else $error("rate counter did not restart");
  a_no_retrig: assert property (s.seq == PTGS_RUN && s.t != s.fin |=> s.t == $past(s.t) + 18'h1) // see RL17
    else $error("running sequence restarted");

  // Idle outputs, rate counter and untruncated pulses
  a_no_truncate: assert property (pulse_out && s.seq == PTGS_RUN && s.t < s.me |=> pulse_out) // see RL12
    else $error("main pulse cut short");
  a_rate_parked: assert property (s.mode != PTGS_INTERNAL |=> s.rate_cnt == 24'h0) // see RL13
    else $error("rate counter ran outside internal mode");
  a_idle_quiet: assert property (s.seq == PTGS_IDLE && $past(s.seq == PTGS_IDLE) |-> !pulse_out && !sync_out) // see RL17
    else $error("output high while idle");

  // Main scenarios
  c_pos_run: cover property (accept && !d_neg && s.delay != 16'h0);
  c_int_accept: cover property (accept && s.mode == PTGS_INTERNAL);
  c_neg_run: cover property (accept && d_neg);
  c_ext_accept: cover property (accept && s.mode == PTGS_EXTERNAL);
  c_gate_drop: cover property (sel_external_edge_input && gate_supp && s.seq == PTGS_IDLE);
endmodule

//--- src/ptgs_cfg.svh
// Offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef PTGS_CFG_SVH
`define PTGS_CFG_SVH

`define PTGS_CLK_MHZ 20
`define PTGS_WIDTH_MIN_NS 2000
`define PTGS_WIDTH_MAX_NS 20000
`define PTGS_SYNC_NS 100
`define PTGS_WIDTH_MIN_CYC ((`PTGS_WIDTH_MIN_NS * `PTGS_CLK_MHZ + 999) / 1000)
`define PTGS_WIDTH_MAX_CYC ((`PTGS_WIDTH_MAX_NS * `PTGS_CLK_MHZ) / 1000)
`define PTGS_SYNC_CYC ((`PTGS_SYNC_NS * `PTGS_CLK_MHZ + 999) / 1000)

`define PTGS_ADDR_W 8
`define PTGS_OFF_CTRL 8'h00
`define PTGS_OFF_WIDTH 8'h04
`define PTGS_OFF_DELAY 8'h08
`define PTGS_OFF_PERIOD 8'h0C
`define PTGS_OFF_STATUS 8'h10

`define PTGS_CTRL_GATE_BIT 2
`define PTGS_RST_GATE_HI 1'h1
`define PTGS_RST_WIDTH 16'h0028
`define PTGS_RST_DELAY 16'h0000
`define PTGS_RST_PERIOD 24'h004E20

`define PTGS_T_W 18
`define PTGS_NPIN 3
`define PTGS_PIN_EXT 0
`define PTGS_PIN_GATE 1
`define PTGS_PIN_BTN 2

`endif

//--- src/ptgs_pkg.sv
// Types shared by the trigger sequencer modules
`include "ptgs_cfg.svh"
package ptgs_pkg;

  typedef enum logic [1:0] {PTGS_INTERNAL, PTGS_EXTERNAL, PTGS_MANUAL, PTGS_HOLD} ptgs_mode_t;

  typedef enum logic {PTGS_IDLE, PTGS_RUN} ptgs_seq_t;

  typedef struct packed {
    logic [`PTGS_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ptgs_wr_t;

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic bvalid;
    logic ar_pend;
    logic rvalid;
    ptgs_wr_t wr;
    logic [`PTGS_ADDR_W-1:0] araddr;
    logic [31:0] rdata;
  } ptgs_axs_t;

  typedef struct packed {
    logic [`PTGS_NPIN-1:0] s1;
    logic [`PTGS_NPIN-1:0] s2;
    logic [`PTGS_NPIN-1:0] s3;
    logic [`PTGS_NPIN-1:0] clean;
  } ptgs_sync_t;

  typedef struct packed {
    ptgs_mode_t mode;
    logic gate_hi;
    logic [15:0] width;
    logic [15:0] delay;
    logic [23:0] period;
    ptgs_seq_t seq;
    logic [`PTGS_T_W-1:0] t;
    logic [`PTGS_T_W-1:0] ms;
    logic [`PTGS_T_W-1:0] me;
    logic [`PTGS_T_W-1:0] ss;
    logic [`PTGS_T_W-1:0] se;
    logic [`PTGS_T_W-1:0] fin;
    logic [23:0] rate_cnt;
    logic [`PTGS_NPIN-1:0] prev;
    logic pulse_out;
    logic sync_out;
  } ptgs_state_t;

endpackage

//--- src/ptgs_insync.sv
// Three-stage synchroniser with agreement filter for the panel pins
`timescale 1ns/1ps
`include "ptgs_cfg.svh"
module ptgs_insync import ptgs_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [`PTGS_NPIN-1:0] raw,
  output logic [`PTGS_NPIN-1:0] clean
);
  ptgs_sync_t s;
  ptgs_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = raw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // Change only once stages two and three agree
    next_s.clean = (s.s2 & s.s3) | (s.clean & (s.s2 | s.s3));
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clean = s.clean;
endmodule

//--- src/ptgs_axil.sv
// AXI4-Lite slave front end for the sequencer registers
`timescale 1ns/1ps
`include "ptgs_cfg.svh"
module ptgs_axil import ptgs_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [`PTGS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PTGS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output ptgs_wr_t wr,
  output logic wr_en,
  output logic [`PTGS_ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data
);
  ptgs_axs_t s;
  ptgs_axs_t next_s;

  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.ar_pend && !s.rvalid;
  // Address and data may land in either order; the write fires once both are held
  assign wr_en = s.aw_held && s.w_held;

  always_comb begin
    next_s = s;
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.wr.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wr.data = s_axi_wdata;
      next_s.wr.strb = s_axi_wstrb;
    end
    if (wr_en) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.ar_pend = 1'b1;
      next_s.araddr = s_axi_araddr;
    end
    if (s.ar_pend) begin
      next_s.ar_pend = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wr = s.wr;
  assign rd_addr = s.araddr;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
endmodule

//--- sim/ptgs_far_model.sv
// Far side: trigger and gate source, scope timing the two outputs
`timescale 1ns/1ps
module ptgs_far_model (
  input wire logic clk_sys,
  input wire logic ext_level,
  input wire logic gate_en,
  input wire logic gate_level,
  input wire logic gate_pull_up,
  input wire logic pulse_out,
  input wire logic sync_out,
  output logic external_edge_input,
  output logic gate_input
);
  int cyc = 0;
  int p_cnt = 0;
  int p_at = 0;
  int p_w = 0;
  int p_gap = 0;
  int s_at = 0;
  int s_w = 0;
  logic p_d = 1'b0;
  logic s_d = 1'b0;
  assign external_edge_input = ext_level;
  // Released gate rests at the resistor level the block selects
  assign gate_input = gate_en ? gate_level : gate_pull_up;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    p_d <= pulse_out;
    s_d <= sync_out;
    if (pulse_out && !p_d) begin
      p_gap <= cyc - p_at;
      p_at <= cyc;
      p_cnt <= p_cnt + 1;
    end
    if (!pulse_out && p_d) p_w <= cyc - p_at;
    if (sync_out && !s_d) s_at <= cyc;
    if (!sync_out && s_d) s_w <= cyc - s_at;
  end
endmodule

//--- sim/tb_pulse_trigger_gate_sequencer.sv
// Self-checking bench for the trigger and gate sequencer
`timescale 1ns/1ps
`include "ptgs_cfg.svh"
module tb_pulse_trigger_gate_sequencer import ptgs_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ext_level = 1'b0, gate_en = 1'b0, gate_level = 1'b0, btn = 1'b0;
  logic ext_pin, gate_pin, pulse_out, sync_out, gate_pull_up;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fail_count = 0;
  int tests_run = 0;
  int w, d, c0;

  always #25 clk_sys = ~clk_sys;

  ptgs_far_model fm (.clk_sys(clk_sys), .ext_level(ext_level), .gate_en(gate_en), .gate_level(gate_level),
    .gate_pull_up(gate_pull_up), .pulse_out(pulse_out), .sync_out(sync_out), .external_edge_input(ext_pin),
    .gate_input(gate_pin));

  ptgs_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .external_edge_input(ext_pin), .gate_input(gate_pin),
    .single_shot_button(btn), .pulse_out(pulse_out), .sync_out(sync_out), .gate_pull_up(gate_pull_up),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t %s: got %0h want %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic give_up;
    fail_count++;
    $display("FAIL %0t bus wait ran out", $time);
    test_done;
  endtask

  // Handshakes sampled at the falling edge, where the slave's readies have settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_t, w_t, b_t;
    int n;
    n = 0;
    b_t = 1'b0;
    @(posedge clk_sys);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b_t) begin
      if (++n > 50) give_up;
      @(negedge clk_sys);
      aw_t = awready; w_t = wready; b_t = bvalid;
      @(posedge clk_sys);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
    logic ar_t, r_t;
    int n;
    n = 0;
    r_t = 1'b0;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!r_t) begin
      if (++n > 50) give_up;
      @(negedge clk_sys);
      ar_t = arready; r_t = rvalid; v = rdata;
      @(posedge clk_sys);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic cfg(input ptgs_mode_t m, input logic g, input int wv, input int dv, input int per);
    axi_wr(`PTGS_OFF_WIDTH, {16'h0000, 16'(wv)});
    axi_wr(`PTGS_OFF_DELAY, {16'h0000, 16'(dv)});
    axi_wr(`PTGS_OFF_PERIOD, {8'h00, 24'(per)});
    axi_wr(`PTGS_OFF_CTRL, {29'h0, g, m});
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Pin held long enough to pass the input filter
  task automatic hit(input bit on_ext);
    @(posedge clk_sys);
    if (on_ext) ext_level <= 1'b1;
    else btn <= 1'b1;
    quiet(8);
    ext_level <= 1'b0;
    btn <= 1'b0;
  endtask

  function automatic int eff_width(input int v);
    return v < `PTGS_WIDTH_MIN_CYC ? `PTGS_WIDTH_MIN_CYC : v > `PTGS_WIDTH_MAX_CYC ? `PTGS_WIDTH_MAX_CYC : v;
  endfunction

  // Second edge lands inside the running sequence and must be dropped
  task automatic run_ext(input int wv, input int dv);
    cfg(PTGS_EXTERNAL, 1'b1, wv, dv, 100);
    c0 = fm.p_cnt;
    hit(1'b1);
    quiet(12);
    hit(1'b1);
    quiet(eff_width(wv) + (dv < 0 ? -dv : dv) + 30);
    check(fm.p_cnt, c0 + 1, "pulse count");
    check(fm.p_w, eff_width(wv), "main width");
    check(fm.s_w, `PTGS_SYNC_CYC, "reference width");
    check(fm.p_at - fm.s_at, dv, "reference to main offset");
  endtask

  initial begin
    void'($urandom(32'h23CB3FEA));
    quiet(10);
    rst_b <= 1'b1;
    axi_rd(`PTGS_OFF_CTRL, rd);
    check(rd, 32'h0000_0007, "ctrl reset");
    axi_rd(`PTGS_OFF_WIDTH, rd);
    check(rd, 32'h0000_0028, "width reset");
    axi_rd(`PTGS_OFF_DELAY, rd);
    check(rd, 32'h0000_0000, "delay reset");
    axi_rd(`PTGS_OFF_PERIOD, rd);
    check(rd, 32'h0000_4E20, "period reset");
    axi_rd(`PTGS_OFF_STATUS, rd);
    check(rd, 32'h0000_0030, "status reset");
    axi_wr(8'h14, 32'hFFFF_FFFF);
    axi_rd(8'h14, rd);
    check(rd, 32'h0000_0000, "unmapped");
    check({28'h0, bresp, rresp}, 32'h0000_0000, "bus responses");
    $display("test registers done");

    run_ext(40, 0);
    run_ext(400, 1);
    run_ext(1000, -1);
    run_ext(10, 37);
    repeat (6) begin
      w = 40 + int'($urandom % 361);
      d = int'($urandom % 121) - 60;
      run_ext(w, d);
    end
    $display("test timing done");

    for (int m = 0; m < 4; m++) begin
      d = 60 + int'($urandom % 141);
      cfg(ptgs_mode_t'(m), 1'b1, 40, 0, d);
      // Let a sequence started by the previous mode finish before counting
      quiet(50);
      c0 = fm.p_cnt;
      hit(1'b1);
      quiet(100);
      hit(1'b0);
      quiet(3 * d + 20);
      if (m == 0) check(fm.p_gap, d, "internal rate");
      else check(fm.p_cnt, c0 + (m == 3 ? 0 : 1), "per-mode count");
    end
    $display("test modes done");

    for (int g = 0; g < 2; g++) begin
      cfg(PTGS_EXTERNAL, g[0], 40, 0, 100);
      c0 = fm.p_cnt;
      gate_en <= 1'b1;
      gate_level <= g[0];
      quiet(10);
      hit(1'b1);
      quiet(80);
      check(fm.p_cnt, c0, "gated trigger");
      gate_level <= !g[0];
      quiet(10);
      hit(1'b1);
      quiet(80);
      check(fm.p_cnt, c0 + 1, "open gate trigger");
      gate_en <= 1'b0;
      quiet(10);
      check(gate_pull_up, !g[0], "gate resting level");
      hit(1'b1);
      quiet(80);
      check(fm.p_cnt, c0 + 2, "unconnected gate trigger");
    end
    $display("test gate done");

    cfg(PTGS_EXTERNAL, 1'b1, 200, 0, 100);
    gate_en <= 1'b1;
    gate_level <= 1'b0;
    c0 = fm.p_cnt;
    hit(1'b1);
    w = 0;
    while (pulse_out !== 1'b1) begin
      if (++w > 50) give_up;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    gate_level <= 1'b1;
    quiet(240);
    check(fm.p_w, 200, "gated pulse width");
    hit(1'b1);
    quiet(80);
    check(fm.p_cnt, c0 + 1, "gate holds after pulse");
    $display("test gate during pulse done");
    test_done;
  end
endmodule
